// ===== byte_fifo.v
`timescale 1ns/10ps
// Synchronous FIFO with valid/ready on both sides.
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset.
  input  wire             mclk_i,
  input  wire             srst_i,
  // Fill side.
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  // Drain side.
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointers wrap naturally because depth is a power of two.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Storage has no reset; data is only read when counted valid.
  always @(posedge mclk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end
endmodule // byte_fifo

// ===== testbench.sv
`timescale 1ns/10ps
// ****************************************************************
// Register, token, receive and prescaler tests.
// ****************************************************************
module testbench;
  logic       mclk_i = 0, srst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0;
  logic       tx_busy_i = 0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
  wire  [7:0] sfr_rdata_o, ep12_tx_control_o, int_enables_o, rx_byte_i;
  wire  [7:0] ep1_tx_data_o, ep0_tx_data_o, ep0_tx_control_o;
  wire  [1:0] handshake_o, tok_ep_i;
  wire  [3:0] tok_pid_i;
  wire  [6:0] tok_addr_i;
  wire        handshake_valid_o, toggle_match_o, usb_tick_o, line_oe_o;
  wire        tok_valid_i, rx_valid_i, rx_data_pid_i, rx_done_i;
  int         err_count = 0, n_tests = 0, k;
  logic [7:0] regs[11] = '{8'he1, 8'he6, 8'he7, 8'he8, 8'he9, 8'hea, 8'heb,
                           8'hec, 8'hed, 8'hee, 8'hef};
  logic [3:0] pids[3] = '{4'hd, 4'h9, 4'h1};
  logic [7:0] flags[3] = '{8'hc0, 8'ha0, 8'h90};
  usb_lowspeed_function_regs u_dut (.mclk_i, .srst_i, .sfr_addr_i,
    .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .tok_valid_i,
    .tok_pid_i, .tok_addr_i, .tok_ep_i, .rx_valid_i, .rx_byte_i,
    .rx_data_pid_i, .rx_done_i, .tx_busy_i, .handshake_o,
    .handshake_valid_o, .toggle_match_o, .usb_tick_o, .line_oe_o,
    .ep1_tx_data_o, .ep0_tx_data_o, .ep0_tx_control_o,
    .ep12_tx_control_o, .int_enables_o);
  usb_host_model #(.ADDR(7'h05)) u_host (.mclk_i, .tok_valid_o(tok_valid_i),
    .tok_pid_o(tok_pid_i), .tok_addr_o(tok_addr_i), .tok_ep_o(tok_ep_i),
    .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i),
    .rx_data_pid_o(rx_data_pid_i), .rx_done_o(rx_done_i));
  // Clock at 10 MHz.
  initial forever #50 mclk_i = ~mclk_i;
  task automatic conclude;
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk_i);
    #1 {sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {a, d, 1'b1};
    @(posedge mclk_i);
    #1 sfr_wr_i = 0;
  endtask
  // Read data is registered, so it is taken one edge after the address.
  task automatic rd(input logic [7:0] a, exp);
    @(posedge mclk_i);
    #1 {sfr_addr_i, sfr_rd_i} = {a, 1'b1};
    @(posedge mclk_i);
    #1 sfr_rd_i = 0;
    check(sfr_rdata_o, exp);
  endtask
  task automatic tok(input logic [3:0] p, input logic [1:0] e, hs);
    u_host.send_token(p, e);
    check({5'h0, handshake_valid_o, handshake_o}, {6'h1, hs});
  endtask
  task automatic reset_all;
    #1 srst_i = 1;
    repeat (3) @(posedge mclk_i);
    #1 srst_i = 0;
    foreach (regs[i]) rd(regs[i], 8'h00);
  endtask
  // Watchdog; the whole sequence needs far fewer than 10000 cycles.
  initial begin
    #1000000;
    err_count++;
    conclude();
  end
  initial begin
    reset_all();
    wr(8'hec, 8'hff);
    rd(8'hec, 8'h1f);
    wr(8'hec, 8'h00);
    rd(8'hec, 8'h00);
    rd(8'he0, 8'h00);
    wr(8'hed, 8'hff);
    rd(8'hed, 8'h80);
    wr(8'he9, 8'h5a);
    check(int_enables_o, 8'h5a);
    // Plain register copies must follow their writes.
    wr(8'he6, 8'h3c);
    check(ep1_tx_data_o, 8'h3c);
    wr(8'he7, 8'hc3);
    check(ep0_tx_data_o, 8'hc3);
    wr(8'hea, 8'h69);
    check(ep0_tx_control_o, 8'h69);
    // Token flags are one-hot; the last token opens endpoint 0 receive.
    wr(8'hee, 8'h85);
    for (int i = 0; i < 3; i++) begin
      u_host.send_token(pids[i], 2'h0);
      rd(8'hed, flags[i]);
    end
    // Nine bytes overfill the eight-deep buffer; the count still says nine.
    u_host.send_data(9, 1'b0, 8'h10);
    rd(8'hed, 8'h99);
    check({7'h0, toggle_match_o}, 8'h00);
    for (int i = 0; i < 8; i++) rd(8'hef, 8'h10 + 8'(i));
    u_host.send_token(4'h1, 2'h0);
    u_host.send_data(2, 1'b1, 8'h40);
    rd(8'hed, 8'h92);
    check({7'h0, toggle_match_o}, 8'h01);
    rd(8'hef, 8'h40);
    rd(8'hef, 8'h41);
    // Handshake selection.
    wr(8'hec, 8'h13);
    tok(4'h1, 2'h0, 2'h1);
    tok(4'h9, 2'h1, 2'h3);
    tok(4'h1, 2'h2, 2'h3);
    wr(8'hec, 8'h0c);
    tok(4'h9, 2'h1, 2'h2);
    wr(8'heb, 8'h20);
    check(ep12_tx_control_o, 8'h20);
    tok(4'h9, 2'h2, 2'h2);
    // Tick period for the three legal prescaler settings.
    for (int p = 0; p < 3; p++) begin
      wr(8'he1, 8'(p));
      k = 0;
      while (usb_tick_o !== 1'b1 && k < 20) begin
        @(posedge mclk_i);
        #1 k++;
      end
      k = 0;
      do begin
        @(posedge mclk_i);
        #1 k++;
      end while (usb_tick_o !== 1'b1 && k < 20);
      check(8'(k), 8'(2 * p + 2));
    end
    // The driver follows transmit one cycle late and then lets go.
    @(posedge mclk_i);
    #1 tx_busy_i = 1;
    @(posedge mclk_i);
    #1 check({7'h0, line_oe_o}, 8'h01);
    tx_busy_i = 0;
    @(posedge mclk_i);
    #1 check({7'h0, line_oe_o}, 8'h00);
    reset_all();
    conclude();
  end
endmodule // testbench

// ===== usb_clk_prescaler.v
`timescale 1ns/10ps
`include "usb_ls_map.vh"
// Divides the MCU clock by two, then by prescaler plus one.
module usb_clk_prescaler (
  // Clock and reset.
  input  wire       mclk_i,
  input  wire       srst_i,
  // Divider setting.
  input  wire [7:0] divide_i,
  // One-cycle enable at the USB logic rate.
  output reg        tick_o
);
  reg       half_q;
  reg [7:0] cnt_q;

  // The fixed half stage runs first, so even a zero setting halves.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      half_q <= 1'b0;
      cnt_q  <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      half_q <= ~half_q;
      tick_o <= 1'b0;
      if (half_q) begin
        if (cnt_q >= divide_i) begin
          cnt_q  <= 8'h00;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule // usb_clk_prescaler

// ===== usb_host_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Cable-side engine model: decoded tokens and data bytes.
// ****************************************************************
module usb_host_model #(
  parameter logic [6:0] ADDR = 7'h05
) (
  input  wire logic       mclk_i,
  output logic            tok_valid_o,
  output logic [3:0]      tok_pid_o,
  output logic [6:0]      tok_addr_o,
  output logic [1:0]      tok_ep_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_byte_o,
  output logic            rx_data_pid_o,
  output logic            rx_done_o
);
  // Idle values; fields hold garbage outside their strobe on purpose.
  initial begin
    {tok_valid_o, rx_valid_o, rx_done_o, rx_data_pid_o} = 4'h0;
    {tok_pid_o, tok_addr_o, tok_ep_o, rx_byte_o} = 21'h0;
  end
  // One token, strobed for a single cycle, then fields inverted.
  task send_token(input logic [3:0] p, input logic [1:0] e);
    @(posedge mclk_i);
    #1 {tok_valid_o, tok_pid_o, tok_addr_o, tok_ep_o} = {1'b1, p, ADDR, e};
    @(posedge mclk_i);
    #1 {tok_valid_o, tok_pid_o, tok_addr_o, tok_ep_o} = {1'b0, ~p, ~ADDR, ~e};
  endtask
  // A data packet of n bytes counting up from base, then end of packet.
  task send_data(input int n, input logic dp, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      #1 {rx_valid_o, rx_byte_o, rx_data_pid_o} = {1'b1, base + 8'(i), dp};
      @(posedge mclk_i);
      #1 {rx_valid_o, rx_byte_o} = {1'b0, ~rx_byte_o};
    end
    @(posedge mclk_i);
    #1 rx_done_o = 1'b1;
    @(posedge mclk_i);
    #1 rx_done_o = 1'b0;
  endtask
endmodule // usb_host_model

// ===== usb_lowspeed_function_regs.v
`timescale 1ns/10ps
`include "usb_ls_map.vh"
module usb_lowspeed_function_regs (
  // Clock and reset.
  input  wire       mclk_i,
  input  wire       srst_i,
  // Special function register port.
  input  wire [7:0] sfr_addr_i,
  input  wire [7:0] sfr_wdata_i,
  input  wire       sfr_wr_i,
  input  wire       sfr_rd_i,
  output reg  [7:0] sfr_rdata_o,
  // Decoded packets from the serial engine.
  input  wire       tok_valid_i,
  input  wire [3:0] tok_pid_i,
  input  wire [6:0] tok_addr_i,
  input  wire [1:0] tok_ep_i,
  input  wire       rx_valid_i,
  input  wire [7:0] rx_byte_i,
  input  wire       rx_data_pid_i,
  input  wire       rx_done_i,
  input  wire       tx_busy_i,
  // Answers to the serial engine.
  output reg  [1:0] handshake_o,
  output reg        handshake_valid_o,
  output reg        toggle_match_o,
  output reg        usb_tick_o,
  output reg        line_oe_o,
  output reg  [7:0] ep1_tx_data_o,
  output reg  [7:0] ep0_tx_data_o,
  output reg  [7:0] ep0_tx_control_o,
  output reg  [7:0] ep12_tx_control_o,
  output reg  [7:0] int_enables_o
);
  // ****************************************************************
  // Register state.
  // ****************************************************************
  reg  [7:0] presc_q;
  reg  [7:0] int_flags_q;
  reg  [4:0] ep_ctrl_q;
  reg  [7:0] rx_status_q;
  reg  [7:0] func_addr_q;
  reg  [7:0] rx_data_q;
  reg  [3:0] rx_cnt_q;
  reg        rx_active_q;
  wire       tick;
  wire       wr_presc;
  wire       wr_ctrl;
  wire       rd_data;
  wire       for_us;
  wire [7:0] fifo_out_data;
  wire       fifo_out_valid;
  wire       ep1_stall;
  wire       ep2_stall;
  wire       ep1_en;
  wire       ep2_en;
  wire       tx_en;
  wire       tx_sel2;
  wire       tx_done;

  assign wr_presc  = sfr_wr_i & (sfr_addr_i == `ADDR_USB_CLOCK_PRESCALER);
  assign wr_ctrl   = sfr_wr_i & (sfr_addr_i == `ADDR_USB_EP_CONTROL);
  assign rd_data   = sfr_rd_i & (sfr_addr_i == `ADDR_EP0_RX_DATA);
  assign for_us    = (tok_addr_i == func_addr_q[6:0]) & func_addr_q[7];
  assign ep1_stall = ep_ctrl_q[`BIT_EP1_STALL];
  assign ep2_stall = ep_ctrl_q[`BIT_EP2_STALL];
  assign ep1_en    = ep_ctrl_q[`BIT_EP1_ENABLE];
  assign ep2_en    = ep_ctrl_q[`BIT_EP2_ENABLE];
  assign tx_en     = ep12_tx_control_o[`BIT_TX_ENABLE];
  assign tx_sel2   = ep12_tx_control_o[`BIT_TX_SELECT];
  assign tx_done   = int_flags_q[`BIT_TX_DONE];

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  usb_clk_prescaler u_presc (
    .mclk_i   (mclk_i),
    .srst_i   (srst_i),
    .divide_i (presc_q),
    .tick_o   (tick)
  );

  // Receive bytes queue here so the core can read at its own pace.
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_rx_fifo (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_data_i   (rx_byte_i),
    .in_valid_i  (rx_valid_i & rx_active_q),
    .in_ready_o  (),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (rd_data)
  );

  // ****************************************************************
  // Software-written registers.
  // ****************************************************************
  always @(posedge mclk_i) begin
    if (srst_i) begin
      presc_q           <= `REG_RESET;
      ep1_tx_data_o     <= `REG_RESET;
      ep0_tx_data_o     <= `REG_RESET;
      int_enables_o     <= `REG_RESET;
      ep0_tx_control_o  <= `REG_RESET;
      ep12_tx_control_o <= `REG_RESET;
      ep_ctrl_q         <= 5'h00;
      func_addr_q       <= `REG_RESET;
    end else if (sfr_wr_i) begin
      if (wr_presc) begin
        presc_q <= sfr_wdata_i;
      end
      if (sfr_addr_i == `ADDR_EP1_TX_DATA) begin
        ep1_tx_data_o <= sfr_wdata_i;
      end
      if (sfr_addr_i == `ADDR_EP0_TX_DATA) begin
        ep0_tx_data_o <= sfr_wdata_i;
      end
      if (sfr_addr_i == `ADDR_USB_INT_ENABLES) begin
        int_enables_o <= sfr_wdata_i;
      end
      if (sfr_addr_i == `ADDR_EP0_TX_CONTROL) begin
        ep0_tx_control_o <= sfr_wdata_i;
      end
      if (sfr_addr_i == `ADDR_EP12_TX_CONTROL) begin
        ep12_tx_control_o <= sfr_wdata_i;
      end
      if (wr_ctrl) begin
        ep_ctrl_q <= sfr_wdata_i[4:0];
      end
      if (sfr_addr_i == `ADDR_USB_FUNC_ADDRESS) begin
        func_addr_q <= sfr_wdata_i;
      end
    end
  end

  // ****************************************************************
  // Token detection and endpoint 0 status.
  // ****************************************************************
  // Software may write the toggle bit; a new token still sets its flag.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      rx_status_q <= `REG_RESET;
      rx_cnt_q    <= 4'h0;
      rx_active_q <= 1'b0;
      int_flags_q <= `REG_RESET;
    end else begin
      if (sfr_wr_i & (sfr_addr_i == `ADDR_EP0_RX_STATUS)) begin
        rx_status_q[`BIT_RX_TOGGLE] <= sfr_wdata_i[7];
      end
      if (sfr_wr_i & (sfr_addr_i == `ADDR_USB_INT_FLAGS)) begin
        int_flags_q <= int_flags_q & sfr_wdata_i;
      end
      if (tok_valid_i & for_us) begin
        rx_status_q[`BIT_SETUP_SEEN] <= (tok_pid_i == `PID_SETUP);
        rx_status_q[`BIT_IN_SEEN]    <= (tok_pid_i == `PID_IN);
        rx_status_q[`BIT_OUT_SEEN]   <= (tok_pid_i == `PID_OUT);
        rx_active_q <= (tok_ep_i == 2'd0) & (tok_pid_i != `PID_IN);
        rx_cnt_q    <= 4'h0;
      end
      // Arrived bytes count up to 15, even ones the full buffer has to drop.
      if (rx_valid_i & rx_active_q & (rx_cnt_q != 4'hf)) begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
      end
      if (rx_done_i & rx_active_q) begin
        rx_status_q[3:0] <= rx_cnt_q;
        rx_active_q      <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Handshake choice for each token addressed to this function.
  // ****************************************************************
  // Stall has priority so a halted endpoint never leaks data or NAK.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      handshake_o       <= `HS_NONE;
      handshake_valid_o <= 1'b0;
      toggle_match_o    <= 1'b0;
    end else begin
      handshake_valid_o <= 1'b0;
      if (rx_done_i & rx_active_q) begin
        toggle_match_o <= (rx_data_pid_i == rx_status_q[`BIT_RX_TOGGLE]);
      end
      if (tok_valid_i & for_us) begin
        handshake_valid_o <= 1'b1;
        handshake_o       <= `HS_NONE;
        if ((tok_ep_i == 2'd1 & ep1_stall) |
            (tok_ep_i == 2'd2 & ep2_stall)) begin
          handshake_o <= `HS_STALL;
        end else if (tok_pid_i == `PID_IN & tok_ep_i != 2'd0) begin
          if (~tx_en | tx_done) begin
            handshake_o <= `HS_NAK;
          end else if (tok_ep_i == 2'd2 & ep2_en & ~tx_sel2) begin
            handshake_o <= `HS_NAK;
          end else if ((tok_ep_i == 2'd1 & ~ep1_en) |
                       (tok_ep_i == 2'd2 & ~ep2_en)) begin
            handshake_o <= `HS_NAK;
          end
        end else if (tok_pid_i == `PID_OUT & tok_ep_i == 2'd0 &
                     ep_ctrl_q[`BIT_AUTO_STATUS_OUT]) begin
          handshake_o <= `HS_ACK;
        end
      end
    end
  end

  // ****************************************************************
  // Read path, receive data and line driver.
  // ****************************************************************
  always @(posedge mclk_i) begin
    if (srst_i) begin
      rx_data_q   <= `REG_RESET;
      sfr_rdata_o <= `REG_RESET;
      usb_tick_o  <= 1'b0;
      line_oe_o   <= 1'b0;
    end else begin
      usb_tick_o <= tick;
      line_oe_o  <= tx_busy_i;
      if (rd_data & fifo_out_valid) begin
        rx_data_q <= fifo_out_data;
      end
      case (sfr_addr_i)
        `ADDR_USB_CLOCK_PRESCALER: sfr_rdata_o <= presc_q;
        `ADDR_EP1_TX_DATA:         sfr_rdata_o <= ep1_tx_data_o;
        `ADDR_EP0_TX_DATA:         sfr_rdata_o <= ep0_tx_data_o;
        `ADDR_USB_INT_FLAGS:       sfr_rdata_o <= int_flags_q;
        `ADDR_USB_INT_ENABLES:     sfr_rdata_o <= int_enables_o;
        `ADDR_EP0_TX_CONTROL:      sfr_rdata_o <= ep0_tx_control_o;
        `ADDR_EP12_TX_CONTROL:     sfr_rdata_o <= ep12_tx_control_o;
        `ADDR_USB_EP_CONTROL:      sfr_rdata_o <= {3'b000, ep_ctrl_q};
        `ADDR_EP0_RX_STATUS:       sfr_rdata_o <= rx_status_q;
        `ADDR_USB_FUNC_ADDRESS:    sfr_rdata_o <= func_addr_q;
        `ADDR_EP0_RX_DATA: begin
          sfr_rdata_o <= fifo_out_valid ? fifo_out_data : rx_data_q;
        end
        default:                   sfr_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // usb_lowspeed_function_regs

// ===== usb_ls_map.vh
`ifndef USB_LS_MAP_VH
`define USB_LS_MAP_VH
// ****************************************************************
// Register addresses.
// ****************************************************************
`define ADDR_USB_CLOCK_PRESCALER 8'he1
`define ADDR_EP1_TX_DATA         8'he6
`define ADDR_EP0_TX_DATA         8'he7
`define ADDR_USB_INT_FLAGS       8'he8
`define ADDR_USB_INT_ENABLES     8'he9
`define ADDR_EP0_TX_CONTROL      8'hea
`define ADDR_EP12_TX_CONTROL     8'heb
`define ADDR_USB_EP_CONTROL      8'hec
`define ADDR_EP0_RX_STATUS       8'hed
`define ADDR_USB_FUNC_ADDRESS    8'hee
`define ADDR_EP0_RX_DATA         8'hef
// ****************************************************************
// Field positions.
// ****************************************************************
`define BIT_EP1_STALL            0
`define BIT_EP2_STALL            1
`define BIT_EP1_ENABLE           2
`define BIT_EP2_ENABLE           3
`define BIT_AUTO_STATUS_OUT      4
`define BIT_TX_SELECT            6
`define BIT_TX_ENABLE            5
`define BIT_TX_DONE              3
`define BIT_RX_TOGGLE            7
`define BIT_SETUP_SEEN           6
`define BIT_IN_SEEN              5
`define BIT_OUT_SEEN             4
// ****************************************************************
// Reset values, token codes and timing.
// ****************************************************************
`define REG_RESET                8'h00
`define PID_SETUP                4'hd
`define PID_IN                   4'h9
`define PID_OUT                  4'h1
`define PID_DATA0                4'h3
`define PID_DATA1                4'hb
`define HS_NONE                  2'h0
`define HS_ACK                   2'h1
`define HS_NAK                   2'h2
`define HS_STALL                 2'h3
`define PRE_FIXED_DIV            2
`endif

// ===== usb_regs_checker.sv
`timescale 1ns/10ps
// ****************************************************************
// Port-level checks of the low-speed function register block.
// ****************************************************************
module usb_regs_checker (
  input logic       mclk_i,
  input logic       srst_i,
  input logic [7:0] sfr_addr_i,
  input logic [7:0] sfr_wdata_i,
  input logic       sfr_wr_i,
  input logic [7:0] sfr_rdata_o,
  input logic       tok_valid_i,
  input logic [3:0] tok_pid_i,
  input logic [6:0] tok_addr_i,
  input logic [1:0] tok_ep_i,
  input logic       tx_busy_i,
  input logic [1:0] handshake_o,
  input logic       handshake_valid_o,
  input logic       usb_tick_o,
  input logic       line_oe_o,
  input logic [7:0] ep12_tx_control_o
);
  logic [7:0] ctl_q;
  logic [7:0] fadr_q;
  wire        hit = tok_valid_i && fadr_q[7] && tok_addr_i == fadr_q[6:0];
  wire        is_in = tok_pid_i == 4'h9;
  wire        is_out = tok_pid_i == 4'h1;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  // Shadow copies of control and address; the checker cannot read them.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctl_q <= 8'h00;
      fadr_q <= 8'h00;
    end else if (sfr_wr_i && sfr_addr_i == 8'hec) begin
      ctl_q <= sfr_wdata_i;
    end else if (sfr_wr_i && sfr_addr_i == 8'hee) begin
      fadr_q <= sfr_wdata_i;
    end
  end
  sequence s_ans(logic [1:0] c);
    handshake_valid_o && handshake_o == c;
  endsequence
  stall_ep1_a: assert property (hit && (is_in || is_out) && tok_ep_i == 2'h1
    && ctl_q[0] |=> s_ans(2'h3)) else $error("ep1 stall not answered");
  stall_ep2_a: assert property (hit && (is_in || is_out) && tok_ep_i == 2'h2
    && ctl_q[1] |=> s_ans(2'h3)) else $error("ep2 stall not answered");
  tx_off_nak_a: assert property (hit && is_in && tok_ep_i == 2'h1
    && !ctl_q[0] && !ep12_tx_control_o[5] |=> s_ans(2'h2))
    else $error("ep1 IN with transmit off not refused");
  wrong_sel_nak_a: assert property (hit && is_in && tok_ep_i == 2'h2
    && !ctl_q[1] && ctl_q[3] && ep12_tx_control_o[5]
    && !ep12_tx_control_o[6] |=> s_ans(2'h2))
    else $error("ep2 IN with selection on ep1 not refused");
  auto_ack_a: assert property (hit && is_out && tok_ep_i == 2'h0
    && ctl_q[4] |=> s_ans(2'h1)) else $error("status OUT not acknowledged");
  ctl_read_a: assert property (sfr_addr_i == 8'hec |=>
    sfr_rdata_o == {3'h0, $past(ctl_q[4:0])}) else $error("control readback");
  tick_gap_a: assert property (usb_tick_o |=> !usb_tick_o)
    else $error("usb tick too frequent");
  oe_release_a: assert property ($fell(tx_busy_i) |-> line_oe_o ##1 !line_oe_o)
    else $error("line driver not released");
endmodule // usb_regs_checker
bind usb_lowspeed_function_regs usb_regs_checker u_chk (.mclk_i, .srst_i,
  .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rdata_o, .tok_valid_i,
  .tok_pid_i, .tok_addr_i, .tok_ep_i, .tx_busy_i, .handshake_o,
  .handshake_valid_o, .usb_tick_o, .line_oe_o, .ep12_tx_control_o);
